/* File: io_space_pkg.sv */
package io_space_pkg;

  localparam int unsigned IO_SPACE_SIZE = 64;
  localparam logic [5:0]  BIT_ACCESS_LAST = 6'h1f;
  localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
  localparam logic [1:0]  CLK_SRC_INTERNAL = 2'h0;
  localparam int unsigned CLK_SRC_LSB = 0;

  localparam logic [5:0] PORT_B_PIN_INPUT          = 6'h00;
  localparam logic [5:0] PORT_B_DIRECTION          = 6'h01;
  localparam logic [5:0] PORT_B_OUTPUT             = 6'h02;
  localparam logic [5:0] PORT_B_PULLUP_ENABLE      = 6'h03;
  localparam logic [5:0] PORT_CONTROL              = 6'h0c;
  localparam logic [5:0] PIN_CHANGE_MASK           = 6'h10;
  localparam logic [5:0] PIN_CHANGE_FLAG           = 6'h11;
  localparam logic [5:0] PIN_CHANGE_CONTROL        = 6'h12;
  localparam logic [5:0] EXT_IRQ_MASK              = 6'h13;
  localparam logic [5:0] EXT_IRQ_FLAG              = 6'h14;
  localparam logic [5:0] EXT_IRQ_SENSE_CONTROL     = 6'h15;
  localparam logic [5:0] DIGITAL_INPUT_DISABLE     = 6'h17;
  localparam logic [5:0] CONVERTER_RESULT          = 6'h19;
  localparam logic [5:0] CONVERTER_CHANNEL_SELECT  = 6'h1b;
  localparam logic [5:0] CONVERTER_TRIGGER_SELECT  = 6'h1c;
  localparam logic [5:0] CONVERTER_CONTROL_STATUS  = 6'h1d;
  localparam logic [5:0] COMPARATOR_CONTROL_STATUS = 6'h1f;
  localparam logic [5:0] TIMER_CAPTURE_LOW         = 6'h22;
  localparam logic [5:0] TIMER_COUNT_HIGH          = 6'h29;
  localparam logic [5:0] TIMER_IRQ_FLAGS           = 6'h2a;
  localparam logic [5:0] TIMER_IRQ_MASK            = 6'h2b;
  localparam logic [5:0] TIMER_CONTROL_C           = 6'h2c;
  localparam logic [5:0] TIMER_CONTROL_B           = 6'h2d;
  localparam logic [5:0] TIMER_CONTROL_A           = 6'h2e;
  localparam logic [5:0] TIMER_GENERAL_CONTROL     = 6'h2f;
  localparam logic [5:0] WATCHDOG_CONTROL_STATUS   = 6'h31;
  localparam logic [5:0] NVM_CONTROL_STATUS        = 6'h32;
  localparam logic [5:0] NVM_COMMAND               = 6'h33;
  localparam logic [5:0] SUPPLY_MONITOR_CONTROL    = 6'h34;
  localparam logic [5:0] POWER_REDUCTION           = 6'h35;
  localparam logic [5:0] CLOCK_PRESCALE            = 6'h36;
  localparam logic [5:0] CLOCK_SOURCE_SELECT       = 6'h37;
  localparam logic [5:0] OSCILLATOR_CALIBRATION    = 6'h39;
  localparam logic [5:0] SLEEP_MODE_CONTROL        = 6'h3a;
  localparam logic [5:0] RESET_CAUSE_FLAGS         = 6'h3b;
  localparam logic [5:0] CONFIG_CHANGE_PROTECT     = 6'h3c;
  localparam logic [5:0] STACK_POINTER_LOW         = 6'h3d;
  localparam logic [5:0] PROCESSOR_STATUS          = 6'h3f;

  // flag bit positions that hardware events set, plus live status bits (comparator output, NVM busy)
  localparam int unsigned CONV_FLAG_BIT = 4;
  localparam int unsigned CMP_FLAG_BIT  = 4;
  localparam int unsigned CMP_OUT_BIT   = 5;
  localparam int unsigned WDT_FLAG_BIT  = 7;
  localparam int unsigned VLM_FLAG_BIT  = 7;
  localparam int unsigned NVM_BUSY_BIT  = 7;

  typedef enum logic [2:0] {
    IO_IDLE,
    IO_READ,
    IO_WRITE,
    IO_SET_BIT,
    IO_CLEAR_BIT,
    IO_SKIP_IF_SET,
    IO_SKIP_IF_CLEAR
  } io_op_t;

  // implemented bits per address; zero marks a reserved location
  function automatic logic [7:0] impl_mask(input logic [5:0] a);
    case (a)
      6'h00, 6'h01, 6'h02, 6'h03, 6'h10, 6'h17, 6'h36, 6'h3a: impl_mask = 8'h0f;
      6'h0c:                                                 impl_mask = 8'h02;
      6'h11, 6'h12, 6'h13, 6'h14:                            impl_mask = 8'h01;
      6'h15, 6'h1b, 6'h35, 6'h37:                            impl_mask = 8'h03;
      6'h1c:                                                 impl_mask = 8'h07;
      6'h1f:                                                 impl_mask = 8'hbf;
      6'h2a, 6'h2b:                                          impl_mask = 8'h27;
      6'h2c:                                                 impl_mask = 8'hc0;
      6'h2d:                                                 impl_mask = 8'hdf;
      6'h2e:                                                 impl_mask = 8'hf3;
      6'h2f:                                                 impl_mask = 8'h81;
      6'h31:                                                 impl_mask = 8'hef;
      6'h32:                                                 impl_mask = 8'h80;
      6'h33:                                                 impl_mask = 8'h3f;
      6'h34:                                                 impl_mask = 8'hc7;
      6'h3b:                                                 impl_mask = 8'h0b;
      6'h19, 6'h1d, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
      6'h28, 6'h29, 6'h39, 6'h3c, 6'h3d, 6'h3e, 6'h3f:       impl_mask = 8'hff;
      default:                                               impl_mask = 8'h00;
    endcase
  endfunction

  // status flags cleared by writing one
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    case (a)
      6'h11, 6'h14: w1c_mask = 8'h01;
      6'h1d, 6'h1f: w1c_mask = 8'h10;
      6'h2a:        w1c_mask = 8'h27;
      6'h31, 6'h34: w1c_mask = 8'h80;
      default:      w1c_mask = 8'h00;
    endcase
  endfunction

  // bits that mirror peripheral state and ignore writes
  function automatic logic [7:0] ro_mask(input logic [5:0] a);
    case (a)
      6'h00:   ro_mask = 8'h0f;
      6'h19:   ro_mask = 8'hff;
      6'h1f:   ro_mask = 8'h20;
      6'h32:   ro_mask = 8'h80;
      default: ro_mask = 8'h00;
    endcase
  endfunction

  // write-only strobe registers read back as zero
  function automatic logic [7:0] read_mask(input logic [5:0] a);
    if (a == 6'h2c || a == 6'h3c) begin
      read_mask = 8'h00;
    end else begin
      read_mask = impl_mask(a);
    end
  endfunction

  function automatic logic [7:0] rw_mask(input logic [5:0] a);
    rw_mask = impl_mask(a) & ~w1c_mask(a) & ~ro_mask(a);
  endfunction

endpackage

/* File: io_register_space.sv */
`timescale 1ns/1ps

// Operation
// - reset selects internal 8 MHz oscillator clock
// - set/clear single bits at 0x00-0x1F
// - core may test single bits at 0x00-0x1F
// - writing one clears flag, zero keeps it
// - bit operation touches only the addressed bit
// - bit operations above 0x1F refused, bytes only
module io_register_space (
  input  wire logic                             clk_in,
  input  wire logic                             rst_b_in,
  input  wire io_space_pkg::io_op_t             io_op_in,
  input  wire logic [5:0]                       io_addr_in,
  input  wire logic [2:0]                       io_bit_in,
  input  wire logic [7:0]                       io_wdata_in,
  input  wire logic [3:0]                       pin_b_in,
  input  wire logic [7:0]                       conv_result_in,
  input  wire logic                             cmp_out_in,
  input  wire logic                             nvm_busy_in,
  input  wire logic                             pin_change_event_in,
  input  wire logic                             ext_irq_event_in,
  input  wire logic [7:0]                       timer_event_in,
  input  wire logic                             conv_done_event_in,
  input  wire logic                             cmp_event_in,
  input  wire logic                             wdt_event_in,
  input  wire logic                             vlm_event_in,
  output logic      [7:0]                       io_rdata_out,
  output logic                                  skip_out,
  output logic                                  io_done_out,
  output logic                                  op_refused_out,
  output logic      [63:0]                      periph_sel_out,
  output logic      [63:0][7:0]                 io_regs_out,
  output logic                                  internal_osc_sel_out
);
  import io_space_pkg::*;

  logic [7:0]       regs_q [IO_SPACE_SIZE];
  logic [7:0]       regs_d [IO_SPACE_SIZE];
  logic [7:0]       hw_set [IO_SPACE_SIZE];
  logic [7:0]       hw_val [IO_SPACE_SIZE];
  logic [3:0]       pin_meta_q;
  logic [3:0]       pin_sync_q;
  logic [7:0]       rd_val;
  logic [7:0]       bit_sel;
  logic             is_bit_op;
  logic             is_test_op;
  logic             in_bit_range;
  logic             addr_mapped;

  // pins are asynchronous to the core clock
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= pin_b_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign bit_sel      = 8'h01 << io_bit_in;
  assign in_bit_range = (io_addr_in <= BIT_ACCESS_LAST);
  assign is_bit_op    = (io_op_in == IO_SET_BIT) || (io_op_in == IO_CLEAR_BIT);
  assign is_test_op   = (io_op_in == IO_SKIP_IF_SET) || (io_op_in == IO_SKIP_IF_CLEAR);
  assign addr_mapped  = (impl_mask(io_addr_in) != 8'h00);

  // event and live-status routing onto the address map
  always_comb begin
    for (int i = 0; i < IO_SPACE_SIZE; i++) begin
      hw_set[i] = 8'h00;
      hw_val[i] = 8'h00;
    end
    hw_set[PIN_CHANGE_FLAG][0]                       = pin_change_event_in;
    hw_set[EXT_IRQ_FLAG][0]                          = ext_irq_event_in;
    hw_set[TIMER_IRQ_FLAGS]                          = timer_event_in & w1c_mask(TIMER_IRQ_FLAGS);
    hw_set[CONVERTER_CONTROL_STATUS][CONV_FLAG_BIT]  = conv_done_event_in;
    hw_set[COMPARATOR_CONTROL_STATUS][CMP_FLAG_BIT]  = cmp_event_in;
    hw_set[WATCHDOG_CONTROL_STATUS][WDT_FLAG_BIT]    = wdt_event_in;
    hw_set[SUPPLY_MONITOR_CONTROL][VLM_FLAG_BIT]     = vlm_event_in;
    hw_val[PORT_B_PIN_INPUT]                         = {4'h0, pin_sync_q};
    hw_val[CONVERTER_RESULT]                         = conv_result_in;
    hw_val[COMPARATOR_CONTROL_STATUS][CMP_OUT_BIT]   = cmp_out_in;
    hw_val[NVM_CONTROL_STATUS][NVM_BUSY_BIT]         = nvm_busy_in;
  end

  // reserved locations and unimplemented bits read as zero
  assign rd_val = ((regs_q[io_addr_in] & ~ro_mask(io_addr_in)) | hw_val[io_addr_in])
                  & read_mask(io_addr_in);

  genvar g;
  generate
    for (g = 0; g < IO_SPACE_SIZE; g++) begin : g_reg
      localparam logic [5:0] ADDR = 6'(g);
      localparam logic [7:0] RW   = rw_mask(ADDR);
      localparam logic [7:0] W1C  = w1c_mask(ADDR);
      logic wr_hit;
      logic bit_hit;

      assign wr_hit  = (io_op_in == IO_WRITE) && (io_addr_in == ADDR);
      // bit ops only land at or below the last bit-access address
      assign bit_hit = is_bit_op && in_bit_range && (io_addr_in == ADDR);

      always_comb begin
        regs_d[g] = regs_q[g];
        if (wr_hit) begin
          regs_d[g] = (regs_d[g] & ~RW) | (io_wdata_in & RW);
          regs_d[g] = regs_d[g] & ~(io_wdata_in & W1C);
        end
        if (bit_hit) begin
          // only the addressed bit is written, so neighbouring flags survive
          if (io_op_in == IO_SET_BIT) begin
            regs_d[g] = regs_d[g] | (bit_sel & RW);
            regs_d[g] = regs_d[g] & ~(bit_sel & W1C);
          end else begin
            regs_d[g] = regs_d[g] & ~(bit_sel & RW);
          end
        end
        // a flag event in the clearing cycle is kept
        regs_d[g] = regs_d[g] | (hw_set[g] & W1C);
      end

      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          regs_q[g] <= REG_RESET_VALUE;
        end else begin
          regs_q[g] <= regs_d[g];
        end
      end

      assign io_regs_out[g] = regs_q[g];
      // select only on real traffic to a mapped location
      assign periph_sel_out[g] = (impl_mask(ADDR) != 8'h00) && (io_addr_in == ADDR)
                                 && (io_op_in != IO_IDLE)
                                 && !((is_bit_op || is_test_op) && !in_bit_range);
    end
  endgenerate

  // reset value of the source field is the internal oscillator
  assign internal_osc_sel_out =
    (regs_q[CLOCK_SOURCE_SELECT][CLK_SRC_LSB +: 2] == CLK_SRC_INTERNAL);

  // answers one cycle after the request
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      io_rdata_out <= 8'h00;
      skip_out     <= 1'b0;
    end else begin
      if (io_op_in == IO_READ) begin
        io_rdata_out <= rd_val;
      end
      if (is_test_op && in_bit_range) begin
        skip_out <= (io_op_in == IO_SKIP_IF_SET) ? rd_val[io_bit_in]
                                                  : !rd_val[io_bit_in];
      end else begin
        skip_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      io_done_out    <= 1'b0;
      op_refused_out <= 1'b0;
    end else begin
      io_done_out    <= (io_op_in != IO_IDLE);
      // refusal shows the core misused the space; logic stays untouched
      op_refused_out <= ((is_bit_op || is_test_op) && !in_bit_range)
                        || ((io_op_in == IO_WRITE) && !addr_mapped);
    end
  end

  // checking helpers: last operation and the byte it met
  io_op_t     last_op_q;
  logic [5:0] last_addr_q;
  logic [2:0] last_bit_q;
  logic [7:0] last_wdata_q;
  logic [7:0] last_byte_q;
  logic [7:0] last_hw_q;
  logic       last_valid_q;
  logic       last_rw_hit;
  logic       last_w1c_hit;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      last_op_q    <= IO_IDLE;
      last_addr_q  <= 6'h00;
      last_bit_q   <= 3'h0;
      last_wdata_q <= 8'h00;
      last_byte_q  <= 8'h00;
      last_hw_q    <= 8'h00;
      last_valid_q <= 1'b0;
    end else begin
      last_op_q    <= io_op_in;
      last_addr_q  <= io_addr_in;
      last_bit_q   <= io_bit_in;
      last_wdata_q <= io_wdata_in;
      last_byte_q  <= regs_q[io_addr_in];
      last_hw_q    <= hw_set[io_addr_in];
      last_valid_q <= 1'b1;
    end
  end

  assign last_rw_hit  = |(rw_mask(last_addr_q) & (8'h01 << last_bit_q));
  assign last_w1c_hit = |(w1c_mask(last_addr_q) & (8'h01 << last_bit_q));

  sequence s_bit_set_low;
    (io_op_in == IO_SET_BIT) && in_bit_range;
  endsequence

  sequence s_bit_clr_low;
    (io_op_in == IO_CLEAR_BIT) && in_bit_range;
  endsequence

  sequence s_answered;
    io_done_out && !op_refused_out;
  endsequence

  sequence s_test_clr_low;
    (io_op_in == IO_SKIP_IF_CLEAR) && in_bit_range;
  endsequence

  sequence s_high_test;
    is_test_op && !in_bit_range;
  endsequence

  sequence s_refused;
    io_done_out && op_refused_out;
  endsequence

  a_osc_after_reset: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(rst_b_in) |-> internal_osc_sel_out && (regs_q[CLOCK_SOURCE_SELECT] == 8'h00))
    else $error("clock source not internal after reset");

  a_set_bit_lands: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_bit_set_low ##1 (last_valid_q && last_rw_hit)
    |-> (regs_q[last_addr_q][last_bit_q]) and s_answered)
    else $error("set bit did not take effect");

  a_clear_bit_lands: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_bit_clr_low ##1 (last_valid_q && last_rw_hit)
    |-> (!regs_q[last_addr_q][last_bit_q]) and s_answered)
    else $error("clear bit did not take effect");

  a_test_bit_answer: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ((io_op_in == IO_SKIP_IF_SET) && in_bit_range)
    |=> (skip_out == $past(rd_val[io_bit_in])) && io_done_out)
    else $error("skip answer does not match tested bit");

  a_w1c_clears: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ((io_op_in == IO_WRITE) ##1 ((last_wdata_q & w1c_mask(last_addr_q) & ~last_hw_q) != 8'h00))
    |-> ((regs_q[last_addr_q] & last_wdata_q & w1c_mask(last_addr_q) & ~last_hw_q) == 8'h00))
    else $error("write one did not clear flag");

  a_w1c_zero_keeps: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (io_op_in == IO_WRITE) |=>
    ((regs_q[last_addr_q] & ~last_wdata_q & last_byte_q & w1c_mask(last_addr_q))
     == (~last_wdata_q & last_byte_q & w1c_mask(last_addr_q))))
    else $error("write zero disturbed flag");

  a_bit_op_isolated: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (s_bit_set_low or s_bit_clr_low) |=>
    (((regs_q[last_addr_q] ^ last_byte_q) & ~(8'h01 << last_bit_q) & ~last_hw_q) == 8'h00))
    else $error("bit operation changed other bits");

  a_high_bit_refused: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (is_bit_op && !in_bit_range) |-> (periph_sel_out == 64'h0)
    ##1 op_refused_out && (regs_q[last_addr_q] == (last_byte_q | (last_hw_q
        & w1c_mask(last_addr_q)))))
    else $error("bit operation above bit range not refused");

  a_reserved_reads_zero: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ((io_op_in == IO_READ) && !addr_mapped) |-> (periph_sel_out == 64'h0)
    ##1 (io_rdata_out == 8'h00))
    else $error("reserved location did not read zero");

  a_test_clr_answer: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_test_clr_low
    |=> (skip_out == !$past(rd_val[io_bit_in])) and s_answered)
    else $error("skip answer does not match cleared bit");

  a_skip_only_tests: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !(is_test_op && in_bit_range)
    |=> !skip_out)
    else $error("skip raised outside a bit test");

  a_high_test_refused: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_high_test |-> (periph_sel_out == 64'h0)
    ##1 ((!skip_out) and s_refused))
    else $error("bit test above bit range not refused");

  a_reserved_write_kept: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ((io_op_in == IO_WRITE) && !addr_mapped) |-> (periph_sel_out == 64'h0)
    ##1 ((regs_q[last_addr_q] == 8'h00) and s_refused))
    else $error("reserved write not refused");

  a_set_beats_clear: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ((io_op_in == IO_WRITE) && ((hw_set[io_addr_in] & io_wdata_in) != 8'h00))
    |=> ((regs_q[last_addr_q] & last_hw_q & last_wdata_q) == (last_hw_q & last_wdata_q)))
    else $error("flag event lost to a clear");

  a_byte_sel_mapped: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ((io_op_in == IO_READ) || (io_op_in == IO_WRITE)) && addr_mapped
    |-> $onehot(periph_sel_out) && periph_sel_out[io_addr_in])
    else $error("byte access did not select its register");

  a_osc_in_reset: assert property (
    @(posedge clk_in) !rst_b_in |=> internal_osc_sel_out)
    else $error("clock source not internal during reset");

  a_set_bit_clears_flag: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_bit_set_low ##1 (last_valid_q && last_w1c_hit && !last_hw_q[last_bit_q])
    |-> !regs_q[last_addr_q][last_bit_q])
    else $error("set bit did not clear its flag");

  a_done_tracks_op: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (io_op_in != IO_IDLE)
    |=> io_done_out)
    else $error("request not answered");

  a_idle_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (io_op_in == IO_IDLE)
    |=> !io_done_out && !op_refused_out)
    else $error("answer without a request");

endmodule

/* File: core_model.sv */
`timescale 1ns/1ps

module core_model (
  input  wire logic                 clk_in,
  input  wire logic [7:0]           io_rdata_in,
  input  wire logic                 skip_in,
  input  wire logic                 io_done_in,
  input  wire logic                 op_refused_in,
  input  wire logic [63:0]          periph_sel_in,
  output io_space_pkg::io_op_t      io_op_out,
  output logic      [5:0]           io_addr_out,
  output logic      [2:0]           io_bit_out,
  output logic      [7:0]           io_wdata_out
);
  import io_space_pkg::*;

  logic        strict;
  logic        done_seen;
  logic        skip;
  logic        refused;
  logic [7:0]  rdata;
  logic [63:0] sel;

  initial begin
    strict = 1'b1;
    done_seen = 1'b0;
    io_op_out = IO_IDLE;
    io_addr_out = 6'h00;
    io_bit_out = 3'h0;
    io_wdata_out = 8'h00;
  end

  // own copy of the holes in the map, kept apart from the design's tables
  function automatic logic reserved_addr(input logic [5:0] a);
    reserved_addr = a inside {[6'h04:6'h0b], [6'h0d:6'h0f], 6'h16, 6'h18, 6'h1a, 6'h1e,
                              6'h20, 6'h21, 6'h30, 6'h38};
  endfunction

  task automatic access(input io_op_t op, input logic [5:0] a, input logic [2:0] b,
                        input logic [7:0] d);
    int i;
    done_seen = 1'b0;
    if (strict && op == IO_WRITE && reserved_addr(a)) begin
      return;
    end
    @(negedge clk_in);
    io_op_out = op;
    io_addr_out = a;
    io_bit_out = b;
    io_wdata_out = d;
    #1 sel = periph_sel_in;
    @(negedge clk_in);
    // released lines show garbage so stale values cannot pass
    io_op_out = IO_IDLE;
    io_addr_out = ~a;
    io_bit_out = ~b;
    io_wdata_out = ~d;
    for (i = 0; i < 4 && !done_seen; i++) begin
      if (io_done_in === 1'b1) begin
        done_seen = 1'b1;
        rdata = io_rdata_in;
        skip = skip_in;
        refused = op_refused_in;
      end else begin
        @(negedge clk_in);
      end
    end
  endtask
endmodule

/* File: tb_io_register_space.sv */
`timescale 1ns/1ps

`define CHECK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[ERR] %0t compare mismatch got %h exp %h", $time, got, exp); \
  end \
end

module tb_io_register_space;
  import io_space_pkg::*;
  logic        clk_in, rst_b_in, cmp_out_in, nvm_busy_in, pin_change_event_in;
  logic        ext_irq_event_in, conv_done_event_in, cmp_event_in, wdt_event_in;
  logic        vlm_event_in, skip_out, io_done_out, op_refused_out, internal_osc_sel_out;
  logic [3:0]  pin_b_in;
  logic [7:0]  conv_result_in, timer_event_in, io_rdata_out;
  logic [63:0] periph_sel_out;
  logic [63:0][7:0] io_regs_out;
  logic [5:0]  io_addr_in;
  logic [2:0]  io_bit_in;
  logic [7:0]  io_wdata_in;
  io_op_t      io_op_in;
  int          n_errors, n_tests, i;
  logic [5:0]  holes [6] = '{6'h04, 6'h0d, 6'h1e, 6'h21, 6'h30, 6'h38};

  always #4 clk_in = ~clk_in;

  io_register_space io_register_space_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .io_op_in(io_op_in), .io_addr_in(io_addr_in), .io_bit_in(io_bit_in),
    .io_wdata_in(io_wdata_in), .pin_b_in(pin_b_in), .conv_result_in(conv_result_in),
    .cmp_out_in(cmp_out_in), .nvm_busy_in(nvm_busy_in),
    .pin_change_event_in(pin_change_event_in), .ext_irq_event_in(ext_irq_event_in),
    .timer_event_in(timer_event_in), .conv_done_event_in(conv_done_event_in),
    .cmp_event_in(cmp_event_in), .wdt_event_in(wdt_event_in), .vlm_event_in(vlm_event_in),
    .io_rdata_out(io_rdata_out), .skip_out(skip_out), .io_done_out(io_done_out),
    .op_refused_out(op_refused_out), .periph_sel_out(periph_sel_out),
    .io_regs_out(io_regs_out),
    .internal_osc_sel_out(internal_osc_sel_out));

  core_model core_model_inst (.clk_in(clk_in), .io_rdata_in(io_rdata_out),
    .skip_in(skip_out), .io_done_in(io_done_out), .op_refused_in(op_refused_out),
    .periph_sel_in(periph_sel_out), .io_op_out(io_op_in), .io_addr_out(io_addr_in),
    .io_bit_out(io_bit_in), .io_wdata_out(io_wdata_in));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic go(input io_op_t op, input logic [5:0] a, input logic [2:0] b,
                    input logic [7:0] d);
    core_model_inst.access(op, a, b, d);
    if (!core_model_inst.done_seen) begin
      n_errors++;
      $display("[ERR] %0t no completion seen", $time);
      test_done();
    end
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
    go(IO_READ, a, 3'h0, 8'h00);
    `CHECK(core_model_inst.rdata, e)
  endtask

  task automatic chk_op(input io_op_t op, input logic [5:0] a, input logic [2:0] b,
                        input logic es, input logic er);
    go(op, a, b, 8'h00);
    `CHECK(core_model_inst.skip, es)
    `CHECK(core_model_inst.refused, er)
  endtask

  task automatic do_reset();
    @(negedge clk_in);
    rst_b_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
  endtask

  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    {cmp_out_in, nvm_busy_in, pin_change_event_in, ext_irq_event_in} = 4'h0;
    {conv_done_event_in, cmp_event_in, wdt_event_in, vlm_event_in} = 4'h0;
    pin_b_in = 4'h0;
    conv_result_in = 8'h00;
    timer_event_in = 8'h00;
    n_errors = 0;
    n_tests = 0;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    `CHECK(internal_osc_sel_out, 1'b1)
    chk_rd(CLOCK_SOURCE_SELECT, 8'h00);
    go(IO_WRITE, CLOCK_SOURCE_SELECT, 3'h0, 8'h02);
    `CHECK(internal_osc_sel_out, 1'b0)
    go(IO_WRITE, PORT_B_OUTPUT, 3'h0, 8'h05);
    do_reset();
    `CHECK(internal_osc_sel_out, 1'b1)
    chk_rd(PORT_B_OUTPUT, 8'h00);
    $display("clock source after reset checked");

    for (i = 0; i < 4; i++) begin
      chk_op(IO_SET_BIT, PORT_B_DIRECTION, i[2:0], 1'b0, 1'b0);
      chk_rd(PORT_B_DIRECTION, 8'((16'h1 << (i + 1)) - 1));
    end
    chk_op(IO_CLEAR_BIT, PORT_B_DIRECTION, 3'h2, 1'b0, 1'b0);
    chk_rd(PORT_B_DIRECTION, 8'h0b);
    chk_op(IO_SET_BIT, COMPARATOR_CONTROL_STATUS, 3'h7, 1'b0, 1'b0);
    cmp_out_in = 1'b1;
    chk_rd(COMPARATOR_CONTROL_STATUS, 8'ha0);
    chk_op(IO_SKIP_IF_SET, COMPARATOR_CONTROL_STATUS, 3'h5, 1'b1, 1'b0);
    chk_op(IO_SKIP_IF_CLEAR, COMPARATOR_CONTROL_STATUS, 3'h6, 1'b1, 1'b0);
    pin_b_in = 4'ha;
    repeat (4) @(negedge clk_in);
    chk_rd(PORT_B_PIN_INPUT, 8'h0a);
    chk_op(IO_SKIP_IF_SET, PORT_B_PIN_INPUT, 3'h1, 1'b1, 1'b0);
    chk_op(IO_SKIP_IF_SET, PORT_B_PIN_INPUT, 3'h0, 1'b0, 1'b0);
    chk_op(IO_SKIP_IF_CLEAR, PORT_B_PIN_INPUT, 3'h0, 1'b1, 1'b0);
    chk_op(IO_SKIP_IF_CLEAR, PORT_B_PIN_INPUT, 3'h3, 1'b0, 1'b0);
    $display("bit set clear and test checked");

    @(negedge clk_in);
    conv_done_event_in = 1'b1;
    ext_irq_event_in = 1'b1;
    timer_event_in = 8'hff;
    @(negedge clk_in);
    {conv_done_event_in, ext_irq_event_in} = 2'b00;
    timer_event_in = 8'h00;
    chk_rd(CONVERTER_CONTROL_STATUS, 8'h10);
    go(IO_WRITE, CONVERTER_CONTROL_STATUS, 3'h0, 8'h00);
    chk_rd(CONVERTER_CONTROL_STATUS, 8'h10);
    chk_op(IO_SET_BIT, CONVERTER_CONTROL_STATUS, 3'h0, 1'b0, 1'b0);
    chk_rd(CONVERTER_CONTROL_STATUS, 8'h11);
    chk_op(IO_CLEAR_BIT, CONVERTER_CONTROL_STATUS, 3'h0, 1'b0, 1'b0);
    chk_rd(CONVERTER_CONTROL_STATUS, 8'h10);
    go(IO_WRITE, CONVERTER_CONTROL_STATUS, 3'h0, 8'h11);
    chk_rd(CONVERTER_CONTROL_STATUS, 8'h01);
    chk_op(IO_CLEAR_BIT, EXT_IRQ_FLAG, 3'h0, 1'b0, 1'b0);
    chk_rd(EXT_IRQ_FLAG, 8'h01);
    chk_op(IO_SET_BIT, EXT_IRQ_FLAG, 3'h0, 1'b0, 1'b0);
    chk_rd(EXT_IRQ_FLAG, 8'h00);
    chk_rd(TIMER_IRQ_FLAGS, 8'h27);
    go(IO_WRITE, TIMER_IRQ_FLAGS, 3'h0, 8'h01);
    chk_rd(TIMER_IRQ_FLAGS, 8'h26);
    `CHECK(io_regs_out[TIMER_IRQ_FLAGS], 8'h26)
    conv_result_in = 8'h5a;
    nvm_busy_in = 1'b1;
    {pin_change_event_in, cmp_event_in, wdt_event_in, vlm_event_in} = 4'hf;
    @(negedge clk_in);
    {pin_change_event_in, cmp_event_in, vlm_event_in} = 3'h0;
    // event held across the clearing write: the flag must survive
    go(IO_WRITE, WATCHDOG_CONTROL_STATUS, 3'h0, 8'h80);
    wdt_event_in = 1'b0;
    chk_rd(WATCHDOG_CONTROL_STATUS, 8'h80);
    chk_rd(PIN_CHANGE_FLAG, 8'h01);
    chk_op(IO_SKIP_IF_SET, COMPARATOR_CONTROL_STATUS, 3'h4, 1'b1, 1'b0);
    go(IO_WRITE, SUPPLY_MONITOR_CONTROL, 3'h0, 8'h80);
    chk_rd(SUPPLY_MONITOR_CONTROL, 8'h00);
    chk_rd(CONVERTER_RESULT, 8'h5a);
    chk_rd(NVM_CONTROL_STATUS, 8'h80);
    $display("flag clearing checked");

    go(IO_WRITE, TIMER_IRQ_MASK, 3'h0, 8'h05);
    chk_op(IO_SET_BIT, TIMER_IRQ_MASK, 3'h1, 1'b0, 1'b1);
    chk_rd(TIMER_IRQ_MASK, 8'h05);
    chk_op(IO_CLEAR_BIT, TIMER_IRQ_MASK, 3'h0, 1'b0, 1'b1);
    chk_rd(TIMER_IRQ_MASK, 8'h05);
    chk_op(IO_SKIP_IF_SET, TIMER_IRQ_MASK, 3'h0, 1'b0, 1'b1);
    chk_op(IO_SKIP_IF_CLEAR, PROCESSOR_STATUS, 3'h0, 1'b0, 1'b1);
    $display("bit access range checked");

    for (i = 0; i < 6; i++) begin
      chk_rd(holes[i], 8'h00);
      `CHECK(core_model_inst.sel, 64'h0)
    end
    chk_rd(TIMER_IRQ_MASK, 8'h05);
    `CHECK(core_model_inst.sel, 64'h1 << TIMER_IRQ_MASK)
    core_model_inst.strict = 1'b0;
    go(IO_WRITE, 6'h38, 3'h0, 8'hff);
    `CHECK(core_model_inst.refused, 1'b1)
    `CHECK(core_model_inst.sel, 64'h0)
    core_model_inst.strict = 1'b1;
    chk_rd(6'h38, 8'h00);
    $display("reserved locations checked");
    test_done();
  end
endmodule
